// ==== gpe_pins_model.sv ====
// Board model: pin wires and reset straps
module gpe_pins_model (
  input  wire gpe_pkg::gpe_ports_s  drv_in,
  input  wire gpe_pkg::gpe_ports_s  oe_in,
  input  wire gpe_pkg::gpe_ports_s  ext_in,
  input  wire logic                 emu_in,
  output gpe_pkg::gpe_ports_s       pin_out,
  output gpe_pkg::gpe_straps_s      straps_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Wire level: an enabled block driver wins over the board
  assign pin_out = (drv_in & oe_in) | (ext_in & ~oe_in);
  // Straps move only with emu_in, so reset and the sync window always see them
  assign straps_out = emu_in ? 4'h8 : 4'hF;
endmodule

// ==== gpe_pkg.sv ====
// Shared constants, carriers and states of the port block
package gpe_pkg;

  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_ABGH_DATA  = 8'h00;
  localparam logic [7:0]  OFS_E_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_E_ALIAS    = 8'h08;
  localparam logic [7:0]  OFS_GH_DIR     = 8'h0C;
  localparam logic [7:0]  OFS_SEL_ASSIGN = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;

  // ==========================================================
  // Byte lanes and bit positions
  localparam int unsigned LANE_A      = 0;
  localparam int unsigned LANE_B      = 1;
  localparam int unsigned LANE_G      = 2;
  localparam int unsigned LANE_H      = 3;
  localparam int unsigned LANE_E_DATA = 0;
  localparam int unsigned LANE_E_DIR  = 1;
  localparam int unsigned LANE_E_FUNC = 2;
  localparam int unsigned LANE_AB_DIR = 3;
  localparam int unsigned LANE_G_DIR  = 0;
  localparam int unsigned LANE_H_DIR  = 1;
  localparam int unsigned BIT_DIR_A   = 0;
  localparam int unsigned BIT_DIR_B   = 1;
  localparam int unsigned BIT_EMU_PIN = 0;
  localparam int unsigned BIT_BG_PIN  = 1;
  localparam int unsigned BIT_EMU     = 0;
  localparam int unsigned POS_CFG     = 1;
  localparam int unsigned POS_STRAPS  = 4;

  // ==========================================================
  // Bus configurations
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_EXP8   = 2'h1;
  localparam logic [1:0] CFG_EXP16  = 2'h2;

  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] PE_FUNC_BUS    = 8'hFF;
  localparam logic [7:0] PE_FUNC_IO     = 8'h00;
  localparam logic [7:0] DIR_RST        = 8'h00;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [1:0] SEL_ASSIGN_RST = 2'h3;
  localparam int unsigned PORT_ACC_CYC  = 3;
  localparam int unsigned REG_ACC_CYC   = 1;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================
  // Carriers and states
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] g;
    logic [7:0] h;
    logic [7:0] e;
  } gpe_ports_s;

  typedef struct packed {
    logic berr;
    logic d8;
    logic d10;
    logic d1;
  } gpe_straps_s;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_RESP} gpe_state_e;

endpackage

// ==== gpe_sync.sv ====
// Two-stage synchroniser for pin inputs
module gpe_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("gpe_sync: WIDTH must be at least 1");
  end

  // No reset, so strap levels already pass through while reset holds
  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    q_out    <= meta_reg;
  end

endmodule

// ==== gpe_top.sv ====
// General-purpose ports A, B, E, G, H with emulator chip select
//
// Overview of operation
// - Writes latch; output pins drive latched bits
// - Reads: input pins give level, others latch
// - One direction bit per port A, B
// - Port E direction bits per discrete pin
// - Function bit one gives bus control
// - Bits 7..0: SIZ1 SIZ0 AS DS RMC AVEC DSACK1 DSACK0
// - Sample bus error and data 8 at reset
// - Both high: all ones, else zeros
// - Emulator mode: data10 low, berr high, data1 low
// - Emulator mode: port registers go off chip
// - Emulator select asserts on mapped access
// - Port C and F stay internal
// - Port register accesses take three cycles
// - Byte lanes; word and long coherent
// - Port E data at two addresses
// - A, B, G single-chip; H also 8-bit; E always
// - Ports share address and data lines
// - Select pin assignment picks emulator select
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
module gpe_top #(
  parameter int unsigned ACC_CYC = gpe_pkg::PORT_ACC_CYC
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic [7:0]  PORT_A_PIN_IN,
  output logic      [7:0]  PORT_A_PIN_OUT,
  output logic      [7:0]  PORT_A_PIN_OE_OUT,
  input  wire logic [7:0]  PORT_B_PIN_IN,
  output logic      [7:0]  PORT_B_PIN_OUT,
  output logic      [7:0]  PORT_B_PIN_OE_OUT,
  input  wire logic [7:0]  PORT_G_PIN_IN,
  output logic      [7:0]  PORT_G_PIN_OUT,
  output logic      [7:0]  PORT_G_PIN_OE_OUT,
  input  wire logic [7:0]  PORT_H_PIN_IN,
  output logic      [7:0]  PORT_H_PIN_OUT,
  output logic      [7:0]  PORT_H_PIN_OE_OUT,
  input  wire logic [7:0]  PORT_E_PIN_IN,
  output logic      [7:0]  PORT_E_PIN_OUT,
  output logic      [7:0]  PORT_E_PIN_OE_OUT,
  input  wire logic        STRAP_BERR_IN,
  input  wire logic        STRAP_DATA8_IN,
  input  wire logic        STRAP_DATA10_IN,
  input  wire logic        STRAP_DATA1_IN,
  input  wire logic [1:0]  BUS_CFG_IN,
  input  wire logic [15:0] ADDR_LINES_IN,
  input  wire logic [15:0] DATA_LINES_IN,
  input  wire logic        DATA_LINES_OE_IN,
  input  wire logic [7:0]  BUS_CTL_IN,
  input  wire logic [7:0]  BUS_CTL_OE_IN,
  output logic      [7:0]  BUS_CTL_PIN_OUT,
  output logic             EMU_SELECT_N_OUT
);

  if (ACC_CYC < 1 || ACC_CYC > 4) begin : g_chk
    $error("gpe_top: ACC_CYC must be 1 to 4");
  end

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction

  function automatic logic f_ext(input logic [7:0] a);
    return hit(a, gpe_pkg::OFS_ABGH_DATA) | hit(a, gpe_pkg::OFS_E_CTRL) |
           hit(a, gpe_pkg::OFS_E_ALIAS) | hit(a, gpe_pkg::OFS_GH_DIR);
  endfunction

  function automatic logic f_map(input logic [7:0] a);
    return f_ext(a) | hit(a, gpe_pkg::OFS_SEL_ASSIGN) |
           hit(a, gpe_pkg::OFS_STATUS);
  endfunction

  // Input pins read as level, all other bits as the latch
  function automatic logic [7:0] rb(input logic [7:0] pin,
                                    input logic [7:0] lat,
                                    input logic [7:0] in_mask);
    return (pin & in_mask) | (lat & ~in_mask);
  endfunction

  // ==========================================================
  // Pin and strap synchronisers
  gpe_pkg::gpe_ports_s  pin_s;
  gpe_pkg::gpe_straps_s strap_s;

  gpe_sync #(.WIDTH(40)) u_pin_sync (
    .clk_in (CORE_CLK_IN),
    .d_in   ({PORT_A_PIN_IN, PORT_B_PIN_IN, PORT_G_PIN_IN,
              PORT_H_PIN_IN, PORT_E_PIN_IN}),
    .q_out  (pin_s)
  );

  gpe_sync #(.WIDTH(4)) u_strap_sync (
    .clk_in (CORE_CLK_IN),
    .d_in   ({STRAP_BERR_IN, STRAP_DATA8_IN, STRAP_DATA10_IN,
              STRAP_DATA1_IN}),
    .q_out  (strap_s)
  );

  // ==========================================================
  // Strap capture in the first cycle after reset release
  logic                 strap_done_reg;
  gpe_pkg::gpe_straps_s strap_reg;
  logic                 emu_mode_reg;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      strap_done_reg <= 1'b0;
      strap_reg      <= '0;
      emu_mode_reg   <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg      <= strap_s;
      emu_mode_reg   <= !strap_s.d10 && strap_s.berr && !strap_s.d1;
    end
  end

  // Emulator mode is 16-bit expanded whatever BUS_CFG_IN says
  logic [1:0] cfg;
  logic       single;
  logic       h_ok;
  assign cfg    = emu_mode_reg ? gpe_pkg::CFG_EXP16 : BUS_CFG_IN;
  assign single = (cfg == gpe_pkg::CFG_SINGLE);
  assign h_ok   = single || (cfg == gpe_pkg::CFG_EXP8);

  // ==========================================================
  // Bus slave state
  gpe_pkg::gpe_state_e state_reg;
  logic        awready_reg;
  logic        arready_reg;
  logic        bvalid_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;
  logic        is_wr_reg;
  logic [7:0]  addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  cnt_reg;
  logic        emu_sel_n_reg;
  logic [1:0]  sel_assign_reg;
  logic        wr_hs;
  logic        rd_hs;
  logic        commit;
  logic        ext_a;
  logic        local_a;
  logic [7:0]  take_addr;

  assign wr_hs     = awready_reg && S_AXI_AWVALID_IN;
  assign rd_hs     = arready_reg && S_AXI_ARVALID_IN;
  assign commit    = (state_reg == gpe_pkg::ST_BUSY) && (cnt_reg == 2'd0);
  assign ext_a     = f_ext(addr_reg);
  assign local_a   = f_map(addr_reg) && !(emu_mode_reg && ext_a);
  assign take_addr = wr_hs ? S_AXI_AWADDR_IN : S_AXI_ARADDR_IN;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg   <= gpe_pkg::ST_IDLE;
      awready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      is_wr_reg   <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      cnt_reg     <= '0;
    end else begin
      unique case (state_reg)
        gpe_pkg::ST_IDLE: begin
          if (wr_hs || rd_hs) begin
            awready_reg <= 1'b0;
            arready_reg <= 1'b0;
            is_wr_reg   <= wr_hs;
            addr_reg    <= take_addr;
            wdata_reg   <= S_AXI_WDATA_IN;
            wstrb_reg   <= S_AXI_WSTRB_IN;
            // Port registers are slowed to suit off-chip replacements
            cnt_reg     <= f_ext(take_addr) ? 2'(ACC_CYC - 1) :
                           2'(gpe_pkg::REG_ACC_CYC - 1);
            state_reg   <= gpe_pkg::ST_BUSY;
          end else if (!awready_reg && !arready_reg) begin
            // Writes first; both write channels are taken together
            if (S_AXI_AWVALID_IN && S_AXI_WVALID_IN) begin
              awready_reg <= 1'b1;
            end else if (S_AXI_ARVALID_IN) begin
              arready_reg <= 1'b1;
            end
          end
        end
        gpe_pkg::ST_BUSY: begin
          if (commit) begin
            bvalid_reg <= is_wr_reg;
            rvalid_reg <= !is_wr_reg;
            state_reg  <= gpe_pkg::ST_RESP;
          end else begin
            cnt_reg <= cnt_reg - 2'd1;
          end
        end
        gpe_pkg::ST_RESP: begin
          if ((bvalid_reg && S_AXI_BREADY_IN) ||
              (rvalid_reg && S_AXI_RREADY_IN)) begin
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            state_reg  <= gpe_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Emulator select low from take to answer of an off-chip access
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      emu_sel_n_reg <= 1'b1;
    end else if ((wr_hs || rd_hs) && emu_mode_reg && f_ext(take_addr) &&
                 sel_assign_reg[gpe_pkg::BIT_EMU_PIN]) begin
      emu_sel_n_reg <= 1'b0;
    end else if (commit) begin
      emu_sel_n_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Registers
  gpe_pkg::gpe_ports_s data_reg;
  logic [1:0] ab_dir_reg;
  logic [7:0] e_dir_reg;
  logic [7:0] g_dir_reg;
  logic [7:0] h_dir_reg;
  logic [7:0] e_func_reg;
  logic       wr_go;

  assign wr_go = commit && is_wr_reg && local_a;

  function automatic logic [7:0] wb(input logic [7:0]  old,
                                    input int unsigned lane,
                                    input logic [31:0] d,
                                    input logic [3:0]  s);
    return s[lane] ? d[8*lane +: 8] : old;
  endfunction

  // One commit edge updates all lanes, so wide writes are coherent
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      data_reg <= {5{gpe_pkg::DATA_RST}};
    end else if (wr_go) begin
      if (hit(addr_reg, gpe_pkg::OFS_ABGH_DATA)) begin
        data_reg.a <= wb(data_reg.a, gpe_pkg::LANE_A, wdata_reg, wstrb_reg);
        data_reg.b <= wb(data_reg.b, gpe_pkg::LANE_B, wdata_reg, wstrb_reg);
        data_reg.g <= wb(data_reg.g, gpe_pkg::LANE_G, wdata_reg, wstrb_reg);
        data_reg.h <= wb(data_reg.h, gpe_pkg::LANE_H, wdata_reg, wstrb_reg);
      end
      if (hit(addr_reg, gpe_pkg::OFS_E_CTRL) ||
          hit(addr_reg, gpe_pkg::OFS_E_ALIAS)) begin
        data_reg.e <= wb(data_reg.e, gpe_pkg::LANE_E_DATA, wdata_reg,
                         wstrb_reg);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ab_dir_reg <= gpe_pkg::DIR_RST[1:0];
      e_dir_reg  <= gpe_pkg::DIR_RST;
      g_dir_reg  <= gpe_pkg::DIR_RST;
      h_dir_reg  <= gpe_pkg::DIR_RST;
    end else if (wr_go) begin
      if (hit(addr_reg, gpe_pkg::OFS_E_CTRL)) begin
        e_dir_reg <= wb(e_dir_reg, gpe_pkg::LANE_E_DIR, wdata_reg,
                        wstrb_reg);
        if (wstrb_reg[gpe_pkg::LANE_AB_DIR]) begin
          ab_dir_reg <= wdata_reg[8*gpe_pkg::LANE_AB_DIR +: 2];
        end
      end
      if (hit(addr_reg, gpe_pkg::OFS_GH_DIR)) begin
        g_dir_reg <= wb(g_dir_reg, gpe_pkg::LANE_G_DIR, wdata_reg,
                        wstrb_reg);
        h_dir_reg <= wb(h_dir_reg, gpe_pkg::LANE_H_DIR, wdata_reg,
                        wstrb_reg);
      end
    end
  end

  // Function select takes its start value from the straps
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      e_func_reg <= gpe_pkg::PE_FUNC_IO;
    end else if (!strap_done_reg) begin
      e_func_reg <= (strap_s.berr && strap_s.d8) ? gpe_pkg::PE_FUNC_BUS :
                    gpe_pkg::PE_FUNC_IO;
    end else if (wr_go && hit(addr_reg, gpe_pkg::OFS_E_CTRL)) begin
      e_func_reg <= wb(e_func_reg, gpe_pkg::LANE_E_FUNC, wdata_reg,
                       wstrb_reg);
    end
  end

  // Bus grant bit is software's to set; the module select is absent
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_assign_reg <= gpe_pkg::SEL_ASSIGN_RST;
    end else if (wr_go && hit(addr_reg, gpe_pkg::OFS_SEL_ASSIGN) &&
                 wstrb_reg[0]) begin
      sel_assign_reg <= wdata_reg[1:0];
    end
  end

  // ==========================================================
  // Read data and answer
  logic [7:0]  a_in;
  logic [7:0]  b_in;
  logic [7:0]  g_in;
  logic [7:0]  h_in;
  logic [7:0]  e_in;
  logic [31:0] rd_word;

  assign a_in = {8{single && !ab_dir_reg[gpe_pkg::BIT_DIR_A]}};
  assign b_in = {8{single && !ab_dir_reg[gpe_pkg::BIT_DIR_B]}};
  assign g_in = {8{single}} & ~g_dir_reg;
  assign h_in = {8{h_ok}} & ~h_dir_reg;
  assign e_in = ~e_func_reg & ~e_dir_reg;

  always_comb begin
    rd_word = '0;
    if (!local_a) begin
      rd_word = '0;
    end else if (hit(addr_reg, gpe_pkg::OFS_ABGH_DATA)) begin
      rd_word = {rb(pin_s.h, data_reg.h, h_in), rb(pin_s.g, data_reg.g, g_in),
                 rb(pin_s.b, data_reg.b, b_in),
                 rb(pin_s.a, data_reg.a, a_in)};
    end else if (hit(addr_reg, gpe_pkg::OFS_E_CTRL)) begin
      rd_word = {6'h00, ab_dir_reg, e_func_reg, e_dir_reg,
                 rb(pin_s.e, data_reg.e, e_in)};
    end else if (hit(addr_reg, gpe_pkg::OFS_E_ALIAS)) begin
      rd_word = {24'h00_0000, rb(pin_s.e, data_reg.e, e_in)};
    end else if (hit(addr_reg, gpe_pkg::OFS_GH_DIR)) begin
      rd_word = {16'h0000, h_dir_reg, g_dir_reg};
    end else if (hit(addr_reg, gpe_pkg::OFS_SEL_ASSIGN)) begin
      rd_word = {30'h0000_0000, sel_assign_reg};
    end else begin
      rd_word = {24'h00_0000, strap_reg, 1'b0, cfg, emu_mode_reg};
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_reg <= '0;
      resp_reg  <= gpe_pkg::RESP_OKAY;
    end else if (commit) begin
      rdata_reg <= rd_word;
      resp_reg  <= f_map(addr_reg) ? gpe_pkg::RESP_OKAY :
                   gpe_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================
  // Pin drivers; lines go to the bus when a port is unavailable
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PORT_A_PIN_OUT    <= '0;
      PORT_A_PIN_OE_OUT <= '0;
      PORT_B_PIN_OUT    <= '0;
      PORT_B_PIN_OE_OUT <= '0;
      PORT_G_PIN_OUT    <= '0;
      PORT_G_PIN_OE_OUT <= '0;
      PORT_H_PIN_OUT    <= '0;
      PORT_H_PIN_OE_OUT <= '0;
      PORT_E_PIN_OUT    <= '0;
      PORT_E_PIN_OE_OUT <= '0;
      BUS_CTL_PIN_OUT   <= '0;
    end else begin
      PORT_A_PIN_OUT    <= single ? data_reg.a : ADDR_LINES_IN[15:8];
      PORT_A_PIN_OE_OUT <= single ? {8{ab_dir_reg[gpe_pkg::BIT_DIR_A]}} :
                           8'hFF;
      PORT_B_PIN_OUT    <= single ? data_reg.b : ADDR_LINES_IN[7:0];
      PORT_B_PIN_OE_OUT <= single ? {8{ab_dir_reg[gpe_pkg::BIT_DIR_B]}} :
                           8'hFF;
      PORT_G_PIN_OUT    <= single ? data_reg.g : DATA_LINES_IN[15:8];
      PORT_G_PIN_OE_OUT <= single ? g_dir_reg :
                           {8{DATA_LINES_OE_IN}};
      PORT_H_PIN_OUT    <= h_ok ? data_reg.h : DATA_LINES_IN[7:0];
      PORT_H_PIN_OE_OUT <= h_ok ? h_dir_reg :
                           {8{DATA_LINES_OE_IN}};
      // Bit order of the control bus matches the pin order
      PORT_E_PIN_OUT    <= (e_func_reg & BUS_CTL_IN) |
                           (~e_func_reg & data_reg.e);
      PORT_E_PIN_OE_OUT <= (e_func_reg & BUS_CTL_OE_IN) |
                           (~e_func_reg & e_dir_reg);
      BUS_CTL_PIN_OUT   <= pin_s.e;
    end
  end

  assign S_AXI_AWREADY_OUT = awready_reg;
  assign S_AXI_WREADY_OUT  = awready_reg;
  assign S_AXI_ARREADY_OUT = arready_reg;
  assign S_AXI_BVALID_OUT  = bvalid_reg;
  assign S_AXI_BRESP_OUT   = resp_reg;
  assign S_AXI_RVALID_OUT  = rvalid_reg;
  assign S_AXI_RRESP_OUT   = resp_reg;
  assign S_AXI_RDATA_OUT   = rdata_reg;
  assign EMU_SELECT_N_OUT  = emu_sel_n_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  logic [7:0] lat_a;
  assign lat_a = data_reg.a;

  sequence s_ext_take;
    wr_hs && f_ext(S_AXI_AWADDR_IN);
  endsequence

  sequence s_port_answer;
    !bvalid_reg [*4] ##1 bvalid_reg;
  endsequence

  a_emu_sel_mode: assert property (
    !emu_sel_n_reg |-> emu_mode_reg && ext_a)
    else $error("emulator select outside a mapped access");
  a_port_acc_time: assert property (
    s_ext_take |-> s_port_answer)
    else $error("port register access not three cycles");
  a_dir_inputs: assert property (
    !strap_done_reg |-> ab_dir_reg == 2'h0 && e_dir_reg == 8'h00 &&
                        g_dir_reg == 8'h00 && h_dir_reg == 8'h00)
    else $error("direction not all inputs after reset");
  a_func_strap: assert property (
    $rose(strap_done_reg) |-> e_func_reg ==
      ((strap_reg.berr && strap_reg.d8) ? 8'hFF : 8'h00))
    else $error("function select start value wrong");
  a_emu_entry: assert property (
    $rose(strap_done_reg) |-> emu_mode_reg ==
      (!strap_reg.d10 && strap_reg.berr && !strap_reg.d1))
    else $error("emulator mode entry wrong");
  a_emu_no_write: assert property (
    (commit && is_wr_reg && emu_mode_reg && ext_a) |=>
      $stable(data_reg) && $stable(e_func_reg))
    else $error("port register changed in emulator mode");
  a_port_a_drive: assert property (
    (single && ab_dir_reg[0]) |=>
      PORT_A_PIN_OE_OUT == 8'hFF && PORT_A_PIN_OUT == $past(lat_a))
    else $error("port A output not driving latch");
  a_pe_bus_ctl: assert property (
    (e_func_reg == 8'hFF) |=> PORT_E_PIN_OE_OUT == $past(BUS_CTL_OE_IN))
    else $error("port E bus control enable not passed");
  a_unmapped_err: assert property (
    (rd_hs && !f_map(S_AXI_ARADDR_IN)) |-> ##2
      rvalid_reg && resp_reg == 2'h2)
    else $error("unmapped read not answered with error");

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the port block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk = 0, rst = 1, emu = 0;
  logic [7:0] ctl_pin;
  logic [15:0] adl = 0;
  int emu_cyc = 0, emu_base = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0, ctl = 0;
  logic [31:0] wd = 0, rnd;
  logic [3:0] ws = 0;
  logic [1:0] cfg = 0, bresp, rresp;
  logic aw_r, w_r, bv, ar_r, rv, emu_n;
  logic [31:0] rd;
  logic [33:0] q[$];
  int fails = 0, check_count = 0, cyc = 0, seed = 36;
  wire gpe_pkg::gpe_ports_s drv, oe, pin;
  wire gpe_pkg::gpe_straps_s st;
  gpe_pkg::gpe_ports_s ext = 40'h5A_69C3_E196;
  // ==========================================================
  // Design and board
  gpe_top i_gpe_top (.CORE_CLK_IN(clk), .RST_IN(rst),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(aw_r),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(w_r), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(ar_r), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
    .PORT_A_PIN_IN(pin.a), .PORT_A_PIN_OUT(drv.a), .PORT_A_PIN_OE_OUT(oe.a),
    .PORT_B_PIN_IN(pin.b), .PORT_B_PIN_OUT(drv.b), .PORT_B_PIN_OE_OUT(oe.b),
    .PORT_G_PIN_IN(pin.g), .PORT_G_PIN_OUT(drv.g), .PORT_G_PIN_OE_OUT(oe.g),
    .PORT_H_PIN_IN(pin.h), .PORT_H_PIN_OUT(drv.h), .PORT_H_PIN_OE_OUT(oe.h),
    .PORT_E_PIN_IN(pin.e), .PORT_E_PIN_OUT(drv.e), .PORT_E_PIN_OE_OUT(oe.e),
    .STRAP_BERR_IN(st.berr), .STRAP_DATA8_IN(st.d8),
    .STRAP_DATA10_IN(st.d10), .STRAP_DATA1_IN(st.d1), .BUS_CFG_IN(cfg),
    .ADDR_LINES_IN(adl), .DATA_LINES_IN(16'h0000),
    .DATA_LINES_OE_IN(1'b0), .BUS_CTL_IN(ctl), .BUS_CTL_OE_IN(8'hFF),
    .BUS_CTL_PIN_OUT(ctl_pin), .EMU_SELECT_N_OUT(emu_n));
  gpe_pins_model i_gpe_pins_model (.drv_in(drv), .oe_in(oe), .ext_in(ext),
    .emu_in(emu), .pin_out(pin), .straps_out(st));
  // ==========================================================
  // Clock, timeout, monitor
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (emu_n === 1'b0) emu_cyc++;
    if (bv === 1'b1 && br) chk({bresp, 32'h0000_0000}, q.pop_front());
    if (rv === 1'b1 && rr) chk({rresp, rd}, q.pop_front());
    if (cyc == 6000) begin
      fails++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    q.push_back({gpe_pkg::RESP_OKAY, 32'h0000_0000});
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge clk); while (aw_r !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    br <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [33:0] x);
    q.push_back(x);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (ar_r !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
  endtask
  task automatic do_rst(input logic m);
    emu <= m;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    do_rst(1'b0);
    rdx(gpe_pkg::OFS_E_CTRL, {2'h0, 32'h00FF_0000});
    rdx(gpe_pkg::OFS_STATUS, {2'h0, 32'h0000_00F0});
    rdx(gpe_pkg::OFS_SEL_ASSIGN, {2'h0, 32'h0000_0003});
    rnd = $random(seed);
    ctl <= rnd[7:0];
    repeat (6) @(posedge clk);
    chk({10'h000, ctl_pin, oe.e, drv.e},
        {10'h000, rnd[7:0], 8'hFF, rnd[7:0]});
    wr(gpe_pkg::OFS_E_CTRL, 32'h0000_0FA5, 4'h7);
    chk({18'h0_0000, oe.e, drv.e & oe.e}, {18'h0_0000, 16'h0F05});
    rdx(gpe_pkg::OFS_E_CTRL, {2'h0, 32'h0000_0F95});
    wr(gpe_pkg::OFS_E_ALIAS, 32'h0000_003C, 4'h1);
    rdx(gpe_pkg::OFS_E_CTRL, {2'h0, 32'h0000_0F9C});
    wr(gpe_pkg::OFS_E_CTRL, 32'h0100_0000, 4'h8);
    rnd = $random(seed);
    wr(gpe_pkg::OFS_ABGH_DATA, rnd, 4'hF);
    chk({18'h0_0000, oe.a | oe.b, drv.a}, {18'h0_0000, 8'hFF, rnd[7:0]});
    chk({26'h000_0000, oe.b}, 34'h0_0000_0000);
    rdx(gpe_pkg::OFS_ABGH_DATA, {2'h0, ext.h, ext.g, ext.b, rnd[7:0]});
    cfg <= gpe_pkg::CFG_EXP8;
    adl <= rnd[31:16];
    wr(gpe_pkg::OFS_ABGH_DATA, 32'h0000_0000, 4'h2);
    rdx(gpe_pkg::OFS_ABGH_DATA, {2'h0, ext.h, rnd[23:16], 8'h00,
        rnd[7:0]});
    chk({18'h0_0000, drv.a, drv.b}, {18'h0_0000, rnd[31:16]});
    rdx(8'h18, {gpe_pkg::RESP_SLVERR, 32'h0000_0000});
    // Second reset with the emulator straps
    do_rst(1'b1);
    rdx(gpe_pkg::OFS_STATUS, {2'h0, 32'h0000_0085});
    emu_base = emu_cyc;
    rdx(gpe_pkg::OFS_ABGH_DATA, {2'h0, 32'h0000_0000});
    chk({33'h0_0000_0000, (emu_cyc != emu_base)}, 34'h0_0000_0001);
    wr(gpe_pkg::OFS_E_CTRL, 32'h0100_FF00, 4'hA);
    chk({26'h000_0000, oe.e}, 34'h0_0000_0000);
    wr(gpe_pkg::OFS_SEL_ASSIGN, 32'h0000_0002, 4'h1);
    emu_base = emu_cyc;
    rdx(gpe_pkg::OFS_ABGH_DATA, {2'h0, 32'h0000_0000});
    chk({33'h0_0000_0000, (emu_cyc != emu_base)}, 34'h0_0000_0000);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
